// File: test_usart_clock_and_frame_format.sv
// Bench for the serial core: APB tasks, async and sync traffic both ways.
// Assumes the peer model and ce held high.
`timescale 1ns/1ps
module test_usart_clock_and_frame_format;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, txd, rxd, sclk_in, sclk_out, sclk_oe, prev_sclk;
    int error_cnt = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    usf_core dut (.clk(clk), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .sclk_in(sclk_in), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe));
    usf_peer u_peer (.clk(clk), .txd(txd), .rxd(rxd), .sclk(sclk_in));
    // -----------------------------------------
    // Verdict, compare and bus tasks
    // -----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Status then data of one queue entry
    task automatic pop(input logic [31:0] st, input logic [31:0] d);
        apb(1'b0, usf_pkg::OFS_STAT, 32'h0);
        chk("stat", st, rd & 32'h7F);
        apb(1'b0, usf_pkg::OFS_DATA, 32'h0);
        chk("data", d, rd & 32'h1FF);
    endtask
    // -----------------------------------------
    // Main sequence
    // -----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, usf_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", 32'h0C00, rd);
        apb(1'b1, 8'h14, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b1, usf_pkg::OFS_BAUD_HI, 32'h0);
        apb(1'b1, usf_pkg::OFS_BAUD_LO, 32'h0);
        apb(1'b1, usf_pkg::OFS_CTRL, 32'h0C03);
        $display("test reset done");
        // Normal speed then double speed transmit
        fork
            u_peer.recv(8);
            apb(1'b1, usf_pkg::OFS_DATA, 32'hA5);
        join
        chk("tx", 32'hA5, {22'h0, u_peer.got});
        repeat (40) @(posedge clk);
        apb(1'b1, usf_pkg::OFS_CTRL, 32'h0C0B);
        u_peer.bit_len = 8;
        fork
            u_peer.recv(8);
            apb(1'b1, usf_pkg::OFS_DATA, 32'h96);
        join
        chk("tx2x", 32'h96, {22'h0, u_peer.got});
        $display("test transmit done");
        // Three back-to-back frames: third waits in the shifter, bad stop
        u_peer.send(8'h3C, 1'b1);
        u_peer.send(8'h81, 1'b1);
        u_peer.send(8'h5A, 1'b0);
        repeat (20) @(posedge clk);
        pop(32'h61, 32'h3C);
        pop(32'h61, 32'h81);
        pop(32'h63, 32'h5A);
        apb(1'b0, usf_pkg::OFS_STAT, 32'h0);
        chk("empty", 32'h60, rd & 32'h7F);
        $display("test receive done");
        // Nine bits, even parity; ninth bit set before the data write
        apb(1'b1, usf_pkg::OFS_CTRL, 32'h1E07);
        u_peer.bit_len = 16;
        fork
            u_peer.recv(10);
            apb(1'b1, usf_pkg::OFS_DATA, 32'hA5);
        join
        chk("tx9p", 32'h3A5, {22'h0, u_peer.got});
        repeat (40) @(posedge clk);
        // Sync master: clock driven out, one bit per two ticks
        apb(1'b1, usf_pkg::OFS_CTRL, 32'h0C53);
        chk("oe", 32'h1, {31'h0, sclk_oe});
        prev_sclk = sclk_out;
        @(posedge clk);
        chk("sclk", {31'h0, ~prev_sclk}, {31'h0, sclk_out});
        u_peer.bit_len = 2;
        fork
            u_peer.recv(8);
            apb(1'b1, usf_pkg::OFS_DATA, 32'h5A);
        join
        chk("txsync", 32'h5A, {22'h0, u_peer.got});
        repeat (40) @(posedge clk);
        // Sync slave: far side clocks one frame in
        apb(1'b1, usf_pkg::OFS_CTRL, 32'h0C13);
        chk("oe0", 32'h0, {31'h0, sclk_oe});
        u_peer.send_sync(8'hC3);
        repeat (8) @(posedge clk);
        pop(32'h61, 32'hC3);
        $display("test sync done");
        // Reset in mid-run brings the defaults back
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, usf_pkg::OFS_CTRL, 32'h0);
        chk("ctrl2", 32'h0C00, rd);
        end_sim();
    end
endmodule

// File: usf_baud_gen.sv
// Baud rate down-counter: one tick each time the count passes zero.
// Assumes divisor is stable except around a low-byte write (reload).
`timescale 1ns/1ps
module usf_baud_gen #(
    parameter int W = usf_pkg::BAUD_W
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Control
    input wire logic [W-1:0] divisor,
    input wire logic reload,
    // Output
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } usf_baud_state_t;

    usf_baud_state_t s_reg;
    usf_baud_state_t s_next;

    // Reload on zero or on low-byte write, else count down
    always_comb begin
        s_next = s_reg;
        tick = ce & (s_reg.cnt == '0);
        if (reload | tick) begin
            s_next.cnt = divisor;
        end else begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_BAUD_LOAD: assert property (ce && (reload || tick) |=> s_reg.cnt == $past(divisor))
        else $error("baud counter did not reload the divisor");
    AST_BAUD_DOWN: assert property (ce && !reload && !tick |=> s_reg.cnt == $past(s_reg.cnt) - 1)
        else $error("baud counter did not count down by one");
endmodule

// File: usf_core.sv
// Serial port core: baud timing, clock modes, framing and receive queue.
// Assumes rxd and sclk_in are synchronous to clk and an APB master on top.
//
// How it works
// - Two receive entries form a circular queue; one data read pops one.
// - Frame error, overrun and ninth bit travel with each queued character.
// - With the queue full a finished character waits in the shifter.
// - Normal, double-speed, sync master and sync slave clock modes exist.
// - In sync mode the pin direction picks master drive or slave sample.
// - Down-counter reloads the divisor at zero or low-byte write, ticking.
// - Transmit bit clock is tick over 16, 8 or 2 by mode, or sclk_in edges as sync slave.
// - Receive recovery runs on ticks with 16 or 8 states.
// - The divisor is twelve bits, from zero to 4095.
// - Double speed acts only in async mode, eight samples per bit.
// - Slave clock passes a synchroniser and an edge detector first.
// - Sync data changes on one clock edge, sampled on the other.
// - Frames: one start, five to nine data, parity option, 1-2 stops.
// - Start, data LSB first, optional parity, stops; back to back allowed.
// - Start is low, stops high, lines idle high.
// - Transmitter and receiver share one frame format setting.
// - Only the first stop bit is checked; zero there is a frame error.
// - Even parity is the xor of data bits; odd is its inverse.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module usf_core #(
    parameter int FIFO_DEPTH = 2,
    parameter int PTR_W = 1
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial lines
    input wire logic rxd,
    output logic txd,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe
);
    typedef struct packed {
        logic [usf_pkg::CTRL_W-1:0] ctrl;
        logic [usf_pkg::BAUD_W-1:0] div;
        logic [31:0] rdata;
        usf_pkg::usf_tx_st_t tx_st;
        usf_pkg::usf_rx_st_t rx_st;
        logic [3:0] tx_cnt;
        logic [3:0] rx_cnt;
        logic [3:0] tx_idx;
        logic [3:0] rx_idx;
        logic [usf_pkg::DATA_W-1:0] tx_buf;
        logic [usf_pkg::DATA_W-1:0] tx_sh;
        logic [usf_pkg::DATA_W-1:0] rx_sh;
        logic tx_full;
        logic tx_par;
        logic txd;
        logic rx_par;
        logic rx_pe;
        logic rx_ferr;
        logic rx_pend;
        logic ovr_pend;
        logic rx_prev;
        logic [1:0] vote;
        usf_pkg::usf_entry_t [FIFO_DEPTH-1:0] fifo;
        logic [PTR_W-1:0] wp;
        logic [PTR_W-1:0] rp;
        logic [PTR_W:0] fill;
        logic xk1;
        logic xk2;
        logic xk3;
        logic sclk;
    } usf_state_t;

    localparam usf_state_t RST = '{
        ctrl: usf_pkg::CTRL_RST,
        tx_st: usf_pkg::TX_IDLE,
        rx_st: usf_pkg::RX_IDLE,
        txd: 1'b1,
        rx_prev: 1'b1,
        default: '0
    };
    localparam logic [PTR_W:0] DEPTH = (PTR_W+1)'(FIFO_DEPTH);

    usf_state_t s_reg;
    usf_state_t s;
    logic tick;
    logic setup;
    logic wr;
    logic rd;
    logic hit;
    logic sync;
    logic master;
    logic slave;
    logic pol;
    logic ds;
    logic par_on;
    logic odd;
    logic rise;
    logic fall;
    logic chg;
    logic smp;
    logic tx_adv;
    logic next_frame;
    logic rx_smp;
    logic bitv;
    logic start_det;
    logic push;
    logic pop;
    logic reload;
    logic [3:0] last;
    logic [3:0] mid;
    logic [3:0] nbits;
    logic [usf_pkg::DATA_W-1:0] mask;
    logic [2:0] size;

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    usf_baud_gen #(
        .W(usf_pkg::BAUD_W)
    ) u_baud (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .divisor(s.div),
        .reload(reload),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s = s_reg;
        setup = psel & ~penable;
        wr = psel & penable & pwrite & ce;
        rd = psel & penable & ~pwrite & ce;
        hit = (paddr == usf_pkg::OFS_DATA) || (paddr == usf_pkg::OFS_STAT) ||
              (paddr == usf_pkg::OFS_CTRL) || (paddr == usf_pkg::OFS_BAUD_LO) ||
              (paddr == usf_pkg::OFS_BAUD_HI);
        reload = wr & (paddr == usf_pkg::OFS_BAUD_LO);

        // One shared format for both directions
        sync = s_reg.ctrl[usf_pkg::C_SYNC];
        master = sync & s_reg.ctrl[usf_pkg::C_DIR];
        slave = sync & ~s_reg.ctrl[usf_pkg::C_DIR];
        pol = s_reg.ctrl[usf_pkg::C_POL];
        ds = s_reg.ctrl[usf_pkg::C_DBL] & ~sync;
        last = ds ? usf_pkg::LAST_DBL : usf_pkg::LAST_NORM;
        mid = ds ? usf_pkg::MID_DBL : usf_pkg::MID_NORM;
        par_on = s_reg.ctrl[usf_pkg::C_PAR+1];
        odd = s_reg.ctrl[usf_pkg::C_PAR];
        size = s_reg.ctrl[usf_pkg::C_SIZE +: 3];
        // Reserved size codes fall back to the low two bits
        nbits = (size == usf_pkg::SIZE_NINE) ? usf_pkg::SIZE_NINE_BITS :
                {2'b00, size[1:0]} + usf_pkg::SIZE_BASE;
        for (int i = 0; i < usf_pkg::DATA_W; i++) begin
            mask[i] = (4'(i) < nbits);
        end

        // Slave clock: first flop only feeds the second
        s.xk1 = sclk_in;
        s.xk2 = s_reg.xk1;
        s.xk3 = s_reg.xk2;
        if (master & tick) begin
            s.sclk = ~s_reg.sclk;
        end
        rise = slave ? (s_reg.xk2 & ~s_reg.xk3) : (master & tick & ~s_reg.sclk);
        fall = slave ? (~s_reg.xk2 & s_reg.xk3) : (master & tick & s_reg.sclk);
        chg = pol ? fall : rise;
        smp = pol ? rise : fall;

        // --------------------------------------------------------------
        // Transmitter
        // --------------------------------------------------------------
        if (tick) begin
            s.tx_cnt = (s_reg.tx_cnt == last) ? 4'h0 : s_reg.tx_cnt + 4'h1;
        end
        tx_adv = sync ? chg : (tick & (s_reg.tx_cnt == last));
        next_frame = 1'b0;
        case (s_reg.tx_st)
            usf_pkg::TX_IDLE: begin
                s.txd = 1'b1;
                next_frame = tx_adv;
            end
            usf_pkg::TX_START: begin
                if (tx_adv) begin
                    s.txd = s_reg.tx_sh[0];
                    s.tx_idx = 4'h0;
                    s.tx_st = usf_pkg::TX_DATA;
                end
            end
            usf_pkg::TX_DATA: begin
                if (tx_adv) begin
                    if (s_reg.tx_idx == nbits - 4'h1) begin
                        s.txd = par_on ? s_reg.tx_par : 1'b1;
                        s.tx_st = par_on ? usf_pkg::TX_PAR : usf_pkg::TX_STOP1;
                    end else begin
                        s.tx_sh = {1'b0, s_reg.tx_sh[usf_pkg::DATA_W-1:1]};
                        s.txd = s_reg.tx_sh[1];
                        s.tx_idx = s_reg.tx_idx + 4'h1;
                    end
                end
            end
            usf_pkg::TX_PAR: begin
                if (tx_adv) begin
                    s.txd = 1'b1;
                    s.tx_st = usf_pkg::TX_STOP1;
                end
            end
            usf_pkg::TX_STOP1: begin
                if (tx_adv) begin
                    if (s_reg.ctrl[usf_pkg::C_STOP2]) begin
                        s.tx_st = usf_pkg::TX_STOP2;
                    end else begin
                        next_frame = 1'b1;
                    end
                end
            end
            usf_pkg::TX_STOP2: begin
                next_frame = tx_adv;
            end
            default: begin
                s.tx_st = usf_pkg::TX_IDLE;
                s.txd = 1'b1;
            end
        endcase
        // Load straight after the last stop bit, so frames run back to back
        if (next_frame) begin
            if (s_reg.tx_full & s_reg.ctrl[usf_pkg::C_TXEN]) begin
                s.tx_sh = s_reg.tx_buf & mask;
                s.tx_par = (^(s_reg.tx_buf & mask)) ^ odd;
                s.tx_full = 1'b0;
                s.txd = 1'b0;
                s.tx_st = usf_pkg::TX_START;
            end else begin
                s.txd = 1'b1;
                s.tx_st = usf_pkg::TX_IDLE;
            end
        end

        // --------------------------------------------------------------
        // Receiver: three centre samples vote in async mode
        // --------------------------------------------------------------
        if (tick) begin
            s.rx_cnt = (s_reg.rx_cnt == last) ? 4'h0 : s_reg.rx_cnt + 4'h1;
            if ((s_reg.rx_cnt == mid - 4'h1) || (s_reg.rx_cnt == mid)) begin
                s.vote = {s_reg.vote[0], rxd};
            end
        end
        rx_smp = sync ? smp : (tick & (s_reg.rx_cnt == mid + 4'h1));
        bitv = sync ? rxd : ((s_reg.vote[1] & s_reg.vote[0]) | (s_reg.vote[1] & rxd) |
                             (s_reg.vote[0] & rxd));
        start_det = s_reg.ctrl[usf_pkg::C_RXEN] &
                    (sync ? (smp & ~rxd) : (s_reg.rx_prev & ~rxd));
        s.rx_prev = rxd;
        case (s_reg.rx_st)
            usf_pkg::RX_IDLE: begin
                if (start_det) begin
                    // A held third character is lost once a new frame begins
                    if (s_reg.rx_pend) begin
                        s.rx_pend = 1'b0;
                        s.ovr_pend = 1'b1;
                    end
                    s.rx_sh = '0;
                    s.rx_idx = 4'h0;
                    s.rx_par = odd;
                    s.rx_pe = 1'b0;
                    s.rx_cnt = 4'h0;
                    s.rx_st = sync ? usf_pkg::RX_DATA : usf_pkg::RX_START;
                end
            end
            usf_pkg::RX_START: begin
                if (rx_smp) begin
                    s.rx_st = bitv ? usf_pkg::RX_IDLE : usf_pkg::RX_DATA;
                end
            end
            usf_pkg::RX_DATA: begin
                if (rx_smp) begin
                    s.rx_sh[s_reg.rx_idx] = bitv;
                    s.rx_par = s_reg.rx_par ^ bitv;
                    s.rx_idx = s_reg.rx_idx + 4'h1;
                    if (s_reg.rx_idx == nbits - 4'h1) begin
                        s.rx_st = par_on ? usf_pkg::RX_PAR : usf_pkg::RX_STOP;
                    end
                end
            end
            usf_pkg::RX_PAR: begin
                if (rx_smp) begin
                    s.rx_pe = s_reg.rx_par ^ bitv;
                    s.rx_st = usf_pkg::RX_STOP;
                end
            end
            usf_pkg::RX_STOP: begin
                // Second stop bit is not looked at
                if (rx_smp) begin
                    s.rx_ferr = ~bitv;
                    s.rx_pend = 1'b1;
                    s.rx_st = usf_pkg::RX_IDLE;
                end
            end
            default: begin
                s.rx_st = usf_pkg::RX_IDLE;
            end
        endcase

        // --------------------------------------------------------------
        // Receive queue
        // --------------------------------------------------------------
        pop = rd & (paddr == usf_pkg::OFS_DATA) & (s_reg.fill != '0);
        push = s.rx_pend & ((s_reg.fill != DEPTH) | pop);
        if (push) begin
            s.fifo[s_reg.wp] = '{ovr: s.ovr_pend, pe: s.rx_pe, ferr: s.rx_ferr,
                                data: s.rx_sh};
            s.wp = s_reg.wp + 1'b1;
            s.ovr_pend = 1'b0;
            s.rx_pend = 1'b0;
        end
        if (pop) begin
            s.rp = s_reg.rp + 1'b1;
        end
        if (push & ~pop) begin
            s.fill = s_reg.fill + 1'b1;
        end else if (pop & ~push) begin
            s.fill = s_reg.fill - 1'b1;
        end

        // --------------------------------------------------------------
        // APB: read data captured in setup, writes take effect in access
        // --------------------------------------------------------------
        if (setup) begin
            s.rdata = '0;
            case (paddr)
                usf_pkg::OFS_DATA: begin
                    s.rdata[usf_pkg::DATA_W-1:0] = s_reg.fifo[s_reg.rp].data;
                end
                usf_pkg::OFS_STAT: begin
                    s.rdata[usf_pkg::S_AVAIL] = (s_reg.fill != '0);
                    s.rdata[usf_pkg::S_FERR] = s_reg.fifo[s_reg.rp].ferr;
                    s.rdata[usf_pkg::S_OVR] = s_reg.fifo[s_reg.rp].ovr;
                    s.rdata[usf_pkg::S_PE] = s_reg.fifo[s_reg.rp].pe;
                    s.rdata[usf_pkg::S_RX9] = s_reg.fifo[s_reg.rp].data[usf_pkg::DATA_W-1];
                    s.rdata[usf_pkg::S_TXEMPTY] = ~s_reg.tx_full;
                    s.rdata[usf_pkg::S_TXIDLE] = ~s_reg.tx_full &
                                                 (s_reg.tx_st == usf_pkg::TX_IDLE);
                end
                usf_pkg::OFS_CTRL: begin
                    s.rdata[usf_pkg::CTRL_W-1:0] = s_reg.ctrl;
                end
                usf_pkg::OFS_BAUD_LO: begin
                    s.rdata[usf_pkg::BAUD_LO_W-1:0] = s_reg.div[usf_pkg::BAUD_LO_W-1:0];
                end
                usf_pkg::OFS_BAUD_HI: begin
                    s.rdata[usf_pkg::BAUD_W-usf_pkg::BAUD_LO_W-1:0] =
                        s_reg.div[usf_pkg::BAUD_W-1:usf_pkg::BAUD_LO_W];
                end
                default: begin
                    s.rdata = '0;
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                usf_pkg::OFS_DATA: begin
                    // A write into a full holding buffer is dropped
                    if (~s_reg.tx_full) begin
                        s.tx_buf = {s_reg.ctrl[usf_pkg::C_TX9],
                                    pwdata[usf_pkg::DATA_W-2:0]};
                        s.tx_full = 1'b1;
                    end
                end
                usf_pkg::OFS_CTRL: begin
                    s.ctrl = pwdata[usf_pkg::CTRL_W-1:0];
                end
                usf_pkg::OFS_BAUD_LO: begin
                    s.div[usf_pkg::BAUD_LO_W-1:0] = pwdata[usf_pkg::BAUD_LO_W-1:0];
                end
                usf_pkg::OFS_BAUD_HI: begin
                    s.div[usf_pkg::BAUD_W-1:usf_pkg::BAUD_LO_W] =
                        pwdata[usf_pkg::BAUD_W-usf_pkg::BAUD_LO_W-1:0];
                end
                default: begin
                    s.div = s_reg.div;
                end
            endcase
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= RST;
        end else if (ce) begin
            s_reg <= s;
        end
    end

    // Outputs
    assign prdata = s_reg.rdata;
    assign pready = ce;
    assign pslverr = psel & penable & ~hit;
    assign txd = s_reg.txd;
    assign sclk_out = s_reg.sclk;
    assign sclk_oe = master;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence stop_zero;
        ce && s_reg.rx_st == usf_pkg::RX_STOP && rx_smp && !bitv;
    endsequence
    sequence frame_begins;
        ce && next_frame && s_reg.tx_full && s_reg.ctrl[usf_pkg::C_TXEN];
    endsequence

    AST_START_LOW: assert property (frame_begins |=> !txd && s_reg.tx_st == usf_pkg::TX_START)
        else $error("start bit not driven low");
    AST_STOP_HIGH: assert property (s_reg.tx_st inside {usf_pkg::TX_STOP1, usf_pkg::TX_STOP2} |-> txd)
        else $error("stop bit not high");
    AST_IDLE_HIGH: assert property (s_reg.tx_st == usf_pkg::TX_IDLE |-> txd)
        else $error("line not idle high");
    AST_FIFO_BOUND: assert property (s_reg.fill <= DEPTH)
        else $error("receive queue overfilled");
    AST_POP_ONE: assert property (pop && !push |=> s_reg.fill == $past(s_reg.fill) - 1)
        else $error("data read did not pop one entry");
    AST_HOLD_THIRD: assert property (ce && s_reg.rx_pend && s_reg.fill == DEPTH && !pop && !start_det
        |=> s_reg.rx_pend && $stable(s_reg.rx_sh))
        else $error("held character lost without new start");
    AST_FRAME_ERR: assert property (stop_zero |=> s_reg.rx_ferr)
        else $error("zero first stop bit not flagged");
    AST_SLAVE_EDGE: assert property (slave && ce && $rose(sclk_in) ##1 ce |=> rise)
        else $error("slave clock edge not seen two clocks after the pin");
    AST_TX_DIV: assert property (ce && !sync && tick && s_reg.tx_cnt == last |=> s_reg.tx_cnt == 4'h0)
        else $error("transmit divider did not wrap");
endmodule

// File: usf_peer.sv
// Remote serial peer: senders on rxd (async or slave clocked), sampler on txd.
// Assumes divisor 0, so one bit lasts bit_len system clocks.
`timescale 1ns/1ps
module usf_peer (
    // Lines
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic sclk
);
    int bit_len = 16;
    logic [9:0] got;
    initial rxd = 1'b1;
    initial sclk = 1'b0;
    // -----------------------------------------
    // Frame sender, stop level chosen by caller
    // -----------------------------------------
    task automatic send(input logic [7:0] d, input logic stp);
        rxd <= 1'b0;
        repeat (bit_len) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= d[i];
            repeat (bit_len) @(posedge clk);
        end
        rxd <= stp;
        repeat (bit_len) @(posedge clk);
        rxd <= 1'b1;
        @(posedge clk);
    endtask
    // Slave clock sender: 8 clk period keeps it under a quarter of clk
    task automatic send_sync(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    // Bounded wait for start, then sample at bit centres
    task automatic recv(input int nb);
        got = '0;
        for (int n = 0; n < 400 && txd !== 1'b0; n++) @(posedge clk);
        repeat (bit_len / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            repeat (bit_len) @(posedge clk);
            got[i] = txd;
        end
    endtask
endmodule

// File: usf_pkg.sv
// Constants and types shared by the serial port core and its baud generator.
// Assumes a single system clock; all offsets are APB byte addresses.
package usf_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_BAUD_LO = 8'h0C;
    localparam logic [7:0] OFS_BAUD_HI = 8'h10;

    // Control register fields
    localparam int C_TXEN = 0;
    localparam int C_RXEN = 1;
    localparam int C_TX9 = 2;
    localparam int C_DBL = 3;
    localparam int C_SYNC = 4;
    localparam int C_POL = 5;
    localparam int C_DIR = 6;
    localparam int C_STOP2 = 7;
    localparam int C_PAR = 8;
    localparam int C_SIZE = 10;
    localparam int CTRL_W = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0C00;

    // Status register fields
    localparam int S_AVAIL = 0;
    localparam int S_FERR = 1;
    localparam int S_OVR = 2;
    localparam int S_PE = 3;
    localparam int S_RX9 = 4;
    localparam int S_TXEMPTY = 5;
    localparam int S_TXIDLE = 6;

    // ------------------------------------------------------------------
    // Baud and frame constants
    // ------------------------------------------------------------------
    localparam int BAUD_W = 12;
    localparam int BAUD_LO_W = 8;
    localparam logic [3:0] LAST_NORM = 4'hF;
    localparam logic [3:0] LAST_DBL = 4'h7;
    localparam logic [3:0] MID_NORM = 4'h8;
    localparam logic [3:0] MID_DBL = 4'h4;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [3:0] SIZE_NINE_BITS = 4'h9;
    localparam logic [3:0] SIZE_BASE = 4'h5;
    localparam int DATA_W = 9;

    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_START = 6'h02,
        TX_DATA = 6'h04,
        TX_PAR = 6'h08,
        TX_STOP1 = 6'h10,
        TX_STOP2 = 6'h20
    } usf_tx_st_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } usf_rx_st_t;

    typedef struct packed {
        logic ovr;
        logic pe;
        logic ferr;
        logic [DATA_W-1:0] data;
    } usf_entry_t;

endpackage
